/* File: rtl/i2cs_consts.svh */
// Contract
// - a byte written to the data register is shifted out on the next master read
// - the target works only while its enable is set
// - answer only when the address after a start matches an own address
// - two own addresses; index 0 is primary, index 1 secondary
// - a data register read returns the last received byte in bits 7:0
// - a start condition latches the start interrupt source
// - a stop condition latches the stop interrupt source
// - data interrupt when a byte arrived or a byte to send is needed
// - each source has a mask bit gating it onto the interrupt line
// - one overall enable switches the whole target interrupt
// - software reads raw and masked interrupt status
// - a clear drops exactly the named sources, others keep their state; a named source set again in the same cycle stays set
// - action status is the no-request code when nothing is pending
// - receive-request code after a byte arrived until software reads it
// - transmit-request code while the master waits for a byte
// - first-byte code when the byte is the first after the address
`ifndef I2CS_CONSTS_SVH
`define I2CS_CONSTS_SVH
// ==========================================
// register offsets
`define I2CS_OFF_CTRL 8'h00
`define I2CS_OFF_OWN0 8'h04
`define I2CS_OFF_OWN1 8'h08
`define I2CS_OFF_DATA 8'h0c
`define I2CS_OFF_STAT 8'h10
`define I2CS_OFF_RIS 8'h14
`define I2CS_OFF_MIS 8'h18
`define I2CS_OFF_IM 8'h1c
`define I2CS_OFF_ICR 8'h20
// ==========================================
// fields and reset values
`define I2CS_CTRL_EN 0
`define I2CS_CTRL_GIE 1
`define I2CS_OWN1_EN 7
`define I2CS_OWN_RESET 7'h00
`define I2CS_MASK_RESET 3'h0
`define I2CS_BYTE_BITS 4'h8
`define I2CS_LAST_TX_BIT 4'h7
// ==========================================
// action status codes
`define I2CS_NO_REQUEST_CODE 4'h0
`define I2CS_RECEIVE_REQUEST_CODE 4'h1
`define I2CS_TRANSMIT_REQUEST_CODE 4'h2
`define I2CS_FIRST_BYTE_RECEIVED_CODE 4'h4
`define I2CS_SECONDARY_MATCH_CODE 4'h8
`endif

/* File: rtl/i2cs_pkg.sv */
package i2cs_pkg;
    // ==========================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_RX = 3'b011,
        ST_RACK = 3'b100,
        ST_TX = 3'b101,
        ST_TACK = 3'b110,
        ST_HOLD = 3'b111
    } i2cs_state_type;

    typedef struct packed {
        logic stop;
        logic start;
        logic data;
    } i2cs_irq_type;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } i2cs_sync_type;

    typedef struct packed {
        i2cs_state_type st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw, sec, ack, first, fbr;
        logic [7:0] rx_byte;
        logic rx_pend;
        logic [7:0] tx_byte;
        logic tx_valid, treq, en, gie, own1_en;
        logic [6:0] own0, own1;
        logic [2:0] mask;
        logic scl_p, sda_p, scl_oe, sda_oe;
        logic a_act, a_wr;
        logic [7:0] a_addr;
        logic [31:0] hrdata;
    } i2cs_regs_type;
endpackage : i2cs_pkg

/* File: rtl/i2cs_sync.sv */
`timescale 1ns/100ps
module i2cs_sync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] pins,
    output logic [1:0] synced
);
    // ==========================================
    // two flops; idle bus level is high
    i2cs_pkg::i2cs_sync_type r, n;

    always_comb begin
        n.s1 = pins;
        n.s2 = r.s1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '{s1: 2'h3, s2: 2'h3};
        end else begin
            r <= n;
        end
    end

    assign synced = r.s2;
endmodule : i2cs_sync

/* File: rtl/i2cs_irq.sv */
`timescale 1ns/100ps
`include "i2cs_consts.svh"
module i2cs_irq (
    input wire logic hclk,
    input wire logic hresetn,
    input wire i2cs_pkg::i2cs_irq_type set,
    input wire logic clr_en,
    input wire logic [2:0] clr,
    input wire logic [2:0] mask,
    input wire logic gie,
    output logic [2:0] raw,
    output logic [2:0] masked,
    output logic irq
);
    // ==========================================
    // sticky sources
    i2cs_pkg::i2cs_irq_type r, n;

    always_comb begin
        n = r;
        if (clr_en) begin
            n = r & ~clr;
        end
        n = n | set; // set beats a clear in the same cycle
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign raw = r;
    assign masked = r & mask;
    assign irq = gie & (|(r & mask));
endmodule : i2cs_irq

/* File: rtl/i2cs_target.sv */
`timescale 1ns/100ps
`include "i2cs_consts.svh"
module i2cs_target (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic irq
);
    // ==========================================
    // declarations
    i2cs_pkg::i2cs_regs_type r, n;
    i2cs_pkg::i2cs_irq_type ev;
    logic [1:0] pins_s;
    logic scl_s, sda_s, rise, fall, start, stop;
    logic acc, wr, dat_wr, clr_en, hit0, hit1, hit;
    logic [2:0] raw, masked;
    logic [3:0] stat;

    function automatic logic addr_match(input logic [6:0] a, input logic [6:0] own, input logic on);
        addr_match = on && (a == own);
    endfunction : addr_match

    // ==========================================
    // pin sampling and bus conditions
    i2cs_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pins({scl_in, sda_in}),
        .synced(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];
    assign rise = scl_s & ~r.scl_p;
    assign fall = ~scl_s & r.scl_p;
    assign start = scl_s & r.scl_p & r.sda_p & ~sda_s;
    assign stop = scl_s & r.scl_p & ~r.sda_p & sda_s;
    assign hit0 = addr_match(r.sh[7:1], r.own0, 1'b1);
    assign hit1 = addr_match(r.sh[7:1], r.own1, r.own1_en);
    assign hit = hit0 | hit1;

    // nothing pending means every bit is clear
    always_comb begin
        stat = `I2CS_NO_REQUEST_CODE;
        if (r.rx_pend) begin
            stat = stat | `I2CS_RECEIVE_REQUEST_CODE;
        end
        if (r.treq) begin
            stat = stat | `I2CS_TRANSMIT_REQUEST_CODE;
        end
        if (r.rx_pend && r.fbr) begin
            stat = stat | `I2CS_FIRST_BYTE_RECEIVED_CODE;
        end
        if (r.sec && (r.rx_pend || r.treq)) begin
            stat = stat | `I2CS_SECONDARY_MATCH_CODE;
        end
    end

    // ==========================================
    // bus slave and engine
    assign acc = hsel & htrans[1] & hready & (hsize == 3'h2);
    assign wr = r.a_act & r.a_wr;
    assign dat_wr = wr && (r.a_addr == `I2CS_OFF_DATA);
    assign clr_en = wr && (r.a_addr == `I2CS_OFF_ICR);

    always_comb begin
        n = r;
        ev = '0;
        n.scl_p = scl_s;
        n.sda_p = sda_s;
        n.a_act = acc;
        if (acc) begin
            n.a_wr = hwrite;
            n.a_addr = haddr[7:0];
        end
        if (acc && !hwrite) begin
            case (haddr[7:0])
                `I2CS_OFF_CTRL: n.hrdata = {30'h0, r.gie, r.en};
                `I2CS_OFF_OWN0: n.hrdata = {25'h0, r.own0};
                `I2CS_OFF_OWN1: n.hrdata = {24'h0, r.own1_en, r.own1};
                `I2CS_OFF_DATA: begin
                    n.hrdata = {24'h0, r.rx_byte};
                    n.rx_pend = 1'b0;
                end
                `I2CS_OFF_STAT: n.hrdata = {28'h0, stat};
                `I2CS_OFF_RIS: n.hrdata = {29'h0, raw};
                `I2CS_OFF_MIS: n.hrdata = {29'h0, masked};
                `I2CS_OFF_IM: n.hrdata = {29'h0, r.mask};
                default: n.hrdata = 32'h0;
            endcase
        end
        if (wr) begin
            case (r.a_addr)
                `I2CS_OFF_CTRL: begin
                    n.en = hwdata[`I2CS_CTRL_EN];
                    n.gie = hwdata[`I2CS_CTRL_GIE];
                end
                `I2CS_OFF_OWN0: n.own0 = hwdata[6:0];
                `I2CS_OFF_OWN1: begin
                    n.own1 = hwdata[6:0];
                    n.own1_en = hwdata[`I2CS_OWN1_EN];
                end
                `I2CS_OFF_DATA: begin
                    n.tx_byte = hwdata[7:0];
                    n.tx_valid = 1'b1;
                end
                `I2CS_OFF_IM: n.mask = hwdata[2:0];
                default: n.mask = r.mask;
            endcase
        end
        // engine follows the bus so a receive beats a same-cycle read
        if (!r.en) begin
            n.st = i2cs_pkg::ST_IDLE;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
            n.treq = 1'b0;
        end else if (stop) begin
            ev.stop = 1'b1;
            n.st = i2cs_pkg::ST_IDLE;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
            n.treq = 1'b0;
        end else if (start) begin
            ev.start = 1'b1;
            n.st = i2cs_pkg::ST_ADDR;
            n.cnt = 4'h0;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
            n.treq = 1'b0;
        end else begin
            case (r.st)
                i2cs_pkg::ST_ADDR: begin
                    if (rise) begin
                        n.sh = {r.sh[6:0], sda_s};
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall && r.cnt == `I2CS_BYTE_BITS) begin
                        if (hit) begin
                            n.sec = ~hit0;
                            n.rw = r.sh[0];
                            n.first = 1'b1;
                            n.sda_oe = 1'b1;
                            n.st = i2cs_pkg::ST_AACK;
                        end else begin
                            n.st = i2cs_pkg::ST_IDLE;
                        end
                    end
                end
                i2cs_pkg::ST_AACK, i2cs_pkg::ST_TACK: begin
                    if (rise) begin
                        n.ack = ~sda_s;
                    end else if (fall) begin
                        n.sda_oe = 1'b0;
                        n.cnt = 4'h0;
                        if (r.st == i2cs_pkg::ST_AACK && !r.rw) begin
                            n.st = i2cs_pkg::ST_RX;
                        end else if (r.st == i2cs_pkg::ST_TACK && !r.ack) begin
                            n.st = i2cs_pkg::ST_IDLE;
                        end else begin
                            n.st = i2cs_pkg::ST_HOLD;
                            n.scl_oe = 1'b1;
                            if (!r.tx_valid) begin
                                n.treq = 1'b1;
                                ev.data = 1'b1;
                            end
                        end
                    end
                end
                i2cs_pkg::ST_HOLD: begin
                    if (r.tx_valid) begin
                        n.sh = r.tx_byte;
                        n.tx_valid = dat_wr;
                        n.treq = 1'b0;
                        n.cnt = 4'h0;
                        n.sda_oe = ~r.tx_byte[7];
                        n.scl_oe = 1'b0;
                        n.st = i2cs_pkg::ST_TX;
                    end
                end
                i2cs_pkg::ST_TX: begin
                    if (fall) begin
                        if (r.cnt == `I2CS_LAST_TX_BIT) begin
                            n.sda_oe = 1'b0;
                            n.st = i2cs_pkg::ST_TACK;
                        end else begin
                            n.sh = {r.sh[6:0], 1'b0};
                            n.sda_oe = ~r.sh[6];
                            n.cnt = r.cnt + 4'h1;
                        end
                    end
                end
                i2cs_pkg::ST_RX: begin
                    if (rise) begin
                        n.sh = {r.sh[6:0], sda_s};
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall && r.cnt == `I2CS_BYTE_BITS) begin
                        // an unread byte is overwritten; no stretch on receive
                        n.rx_byte = r.sh;
                        n.rx_pend = 1'b1;
                        n.fbr = r.first;
                        n.first = 1'b0;
                        ev.data = 1'b1;
                        n.sda_oe = 1'b1;
                        n.st = i2cs_pkg::ST_RACK;
                    end
                end
                i2cs_pkg::ST_RACK: begin
                    if (fall) begin
                        n.sda_oe = 1'b0;
                        n.cnt = 4'h0;
                        n.st = i2cs_pkg::ST_RX;
                    end
                end
                default: n.st = i2cs_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.st <= i2cs_pkg::ST_IDLE;
            r.own0 <= `I2CS_OWN_RESET;
            r.own1 <= `I2CS_OWN_RESET;
            r.mask <= `I2CS_MASK_RESET;
            r.scl_p <= 1'b1;
            r.sda_p <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ==========================================
    // interrupts
    i2cs_irq u_irq (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(ev),
        .clr_en(clr_en),
        .clr(hwdata[2:0]),
        .mask(r.mask),
        .gie(r.gie),
        .raw(raw),
        .masked(masked),
        .irq(irq)
    );

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.hrdata;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = r.scl_oe;
    assign sda_oe = r.sda_oe;

    // ==========================================
    // checks
    property p_tx_load;
        @(posedge hclk) disable iff (!hresetn)
        (r.en && !start && !stop && r.st == i2cs_pkg::ST_HOLD && r.tx_valid)
        |=> (r.st == i2cs_pkg::ST_TX && r.sh == $past(r.tx_byte) && !scl_oe);
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("tx byte not loaded");

    property p_disabled;
        @(posedge hclk) disable iff (!hresetn)
        !r.en |=> (r.st == i2cs_pkg::ST_IDLE && !scl_oe && !sda_oe && !r.treq);
    endproperty
    a_disabled: assert property (p_disabled) else $error("active while disabled");

    property p_no_match;
        @(posedge hclk) disable iff (!hresetn)
        (r.en && !start && !stop && r.st == i2cs_pkg::ST_ADDR && fall && r.cnt == 4'h8 && !hit)
        |=> (r.st == i2cs_pkg::ST_IDLE && !sda_oe);
    endproperty
    a_no_match: assert property (p_no_match) else $error("acked foreign address");

    property p_second;
        @(posedge hclk) disable iff (!hresetn)
        (r.en && !start && !stop && r.st == i2cs_pkg::ST_ADDR && fall && r.cnt == 4'h8 && !hit0 && hit1)
        |=> (r.sec && sda_oe);
    endproperty
    a_second: assert property (p_second) else $error("secondary match lost");

    property p_rx_byte;
        @(posedge hclk) disable iff (!hresetn)
        (r.en && !start && !stop && r.st == i2cs_pkg::ST_RX && fall && r.cnt == 4'h8)
        |=> (r.rx_pend && r.rx_byte == $past(r.sh) && raw[0]);
    endproperty
    a_rx_byte: assert property (p_rx_byte) else $error("receive not captured");

    property p_start;
        @(posedge hclk) disable iff (!hresetn)
        (r.en && start) |=> raw[1];
    endproperty
    a_start: assert property (p_start) else $error("start not latched");

    property p_stop;
        @(posedge hclk) disable iff (!hresetn)
        (r.en && stop) |=> raw[2];
    endproperty
    a_stop: assert property (p_stop) else $error("stop not latched");

    property p_gate;
        @(posedge hclk) disable iff (!hresetn)
        irq == (r.gie && ((raw & r.mask) != 3'h0));
    endproperty
    a_gate: assert property (p_gate) else $error("interrupt gating wrong");

    property p_clear;
        @(posedge hclk) disable iff (!hresetn)
        (clr_en && ev == '0)
        |=> (raw == ($past(raw) & ~$past(hwdata[2:0])));
    endproperty
    a_clear: assert property (p_clear) else $error("clear touched wrong source");

    property p_none;
        @(posedge hclk) disable iff (!hresetn)
        (!r.rx_pend && !r.treq) |-> (stat == 4'h0);
    endproperty
    a_none: assert property (p_none) else $error("status not idle code");

    property p_stretch;
        @(posedge hclk) disable iff (!hresetn)
        r.treq |-> (scl_oe && r.st == i2cs_pkg::ST_HOLD && stat[1]);
    endproperty
    a_stretch: assert property (p_stretch) else $error("request without stretch");
endmodule : i2cs_target

/* File: verification/i2cs_master_model.sv */
`timescale 1ns/100ps
module i2cs_master_model (
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low,
    output logic hung
);
    // ==========================================
    // bus steps
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        hung = 1'b0;
    end

    // steps land on 100 ns marks, never on a rising hclk edge
    task automatic qtr;
        #(100 - ($time % 100));
    endtask : qtr

    // the target may stretch; bounded so a stuck clock cannot hang the run
    task automatic rise;
        int n;
        n = 0;
        scl_low = 1'b0;
        while (scl !== 1'b1 && n < 4000) begin
            #50;
            n++;
        end
        if (n >= 4000) begin
            hung = 1'b1;
        end
    endtask : rise

    task automatic bit_x(input logic o, output logic i);
        qtr;
        sda_low = !o;
        qtr;
        rise;
        qtr;
        qtr;
        i = sda;
        scl_low = 1'b1;
    endtask : bit_x

    task automatic start;
        qtr;
        sda_low = 1'b1;
        qtr;
        scl_low = 1'b1;
    endtask : start

    task automatic stop;
        qtr;
        sda_low = 1'b1;
        qtr;
        rise;
        qtr;
        sda_low = 1'b0;
        qtr;
    endtask : stop

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic x;
        for (int k = 7; k >= 0; k--) bit_x(b[k], x);
        bit_x(1'b1, x);
        ack = !x;
    endtask : wbyte

    task automatic rbyte(input logic ack, output logic [7:0] b);
        logic x;
        for (int k = 7; k >= 0; k--) bit_x(1'b1, b[k]);
        bit_x(!ack, x);
    endtask : rbyte
endmodule : i2cs_master_model

/* File: verification/i2c_slave_controller_tb_top.sv */
`timescale 1ns/100ps
`include "i2cs_consts.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module i2c_slave_controller_tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, scl_out, scl_oe, sda_out, sda_oe, irq;
    logic m_scl_low, m_sda_low, hung;
    wire logic scl_w, sda_w;
    int n_fail = 0;
    int n_tests = 0;
    logic ack;
    logic [7:0] rb;
    logic [7:0] regs [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h40};

    always #25 hclk = !hclk;
    // open-drain wires with pull-ups
    assign scl_w = (scl_oe ? scl_out : 1'b1) & !m_scl_low;
    assign sda_w = (sda_oe ? sda_out : 1'b1) & !m_sda_low;

    i2cs_target uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
    i2cs_master_model mm (.scl(scl_w), .sda(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low), .hung(hung));

    // ==========================================
    // bus tasks
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic waitrdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            end_of_test;
        end
    endtask : waitrdy

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        waitrdy;
        htrans <= 2'b00;
        hwdata <= d;
        waitrdy;
        r = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        `CHK($sformatf("reg %h", a), e, r)
    endtask : rchk

    // ==========================================
    // tests
    initial begin
        int n;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (regs[i]) rchk(regs[i], 32'h0);
        `CHK("hresp", 1'b0, hresp)
        wr(`I2CS_OFF_OWN0, 32'h2a);
        mm.start;
        mm.wbyte(8'h54, ack);
        mm.stop;
        `CHK("ack", 1'b0, ack)
        rchk(`I2CS_OFF_RIS, 32'h0);
        wr(`I2CS_OFF_CTRL, 32'h3);
        wr(`I2CS_OFF_IM, 32'h7);
        mm.start;
        mm.wbyte(8'h54, ack);
        `CHK("ack", 1'b1, ack)
        rchk(`I2CS_OFF_RIS, 32'h2);
        mm.wbyte(8'ha5, ack);
        rchk(`I2CS_OFF_STAT, {28'h0, `I2CS_RECEIVE_REQUEST_CODE | `I2CS_FIRST_BYTE_RECEIVED_CODE});
        rchk(`I2CS_OFF_RIS, 32'h3);
        rchk(`I2CS_OFF_MIS, 32'h3);
        `CHK("irq", 1'b1, irq)
        rchk(`I2CS_OFF_DATA, 32'ha5);
        rchk(`I2CS_OFF_STAT, 32'h0);
        mm.wbyte(8'h3c, ack);
        rchk(`I2CS_OFF_STAT, {28'h0, `I2CS_RECEIVE_REQUEST_CODE});
        mm.stop;
        rchk(`I2CS_OFF_RIS, 32'h7);
        rchk(`I2CS_OFF_DATA, 32'h3c);
        wr(`I2CS_OFF_ICR, 32'h2);
        rchk(`I2CS_OFF_RIS, 32'h5);
        wr(`I2CS_OFF_IM, 32'h2);
        rchk(`I2CS_OFF_MIS, 32'h0);
        `CHK("irq", 1'b0, irq)
        wr(`I2CS_OFF_IM, 32'h4);
        rchk(`I2CS_OFF_MIS, 32'h4);
        wr(`I2CS_OFF_CTRL, 32'h1);
        rchk(`I2CS_OFF_CTRL, 32'h1);
        `CHK("irq", 1'b0, irq)
        wr(`I2CS_OFF_CTRL, 32'h3);
        wr(`I2CS_OFF_ICR, 32'h5);
        rchk(`I2CS_OFF_RIS, 32'h0);
        mm.start;
        mm.wbyte(8'h2a, ack);
        mm.stop;
        `CHK("ack", 1'b0, ack)
        wr(`I2CS_OFF_OWN1, 32'hb3);
        mm.start;
        mm.wbyte(8'h66, ack);
        `CHK("ack", 1'b1, ack)
        mm.wbyte(8'h71, ack);
        rchk(`I2CS_OFF_STAT, 32'hd);
        rchk(`I2CS_OFF_DATA, 32'h71);
        mm.stop;
        mm.start;
        mm.wbyte(8'h55, ack);
        `CHK("ack", 1'b1, ack)
        fork
            mm.rbyte(1'b1, rb);
            begin
                n = 0;
                while (scl_oe !== 1'b1 && n < 400) begin
                    @(posedge hclk);
                    n++;
                end
                if (n >= 400) begin
                    n_fail++;
                    end_of_test;
                end
                rchk(`I2CS_OFF_STAT, {28'h0, `I2CS_TRANSMIT_REQUEST_CODE});
                `CHK("scl_oe", 1'b1, scl_oe)
                wr(`I2CS_OFF_DATA, 32'h96);
            end
        join
        `CHK("rx", 8'h96, rb)
        wr(`I2CS_OFF_DATA, 32'h5b);
        mm.rbyte(1'b0, rb);
        `CHK("rx", 8'h5b, rb)
        mm.stop;
        rchk(`I2CS_OFF_STAT, 32'h0);
        // byte written before the read: only a one-cycle stretch
        wr(`I2CS_OFF_DATA, 32'hc3);
        mm.start;
        mm.wbyte(8'h55, ack);
        `CHK("ack", 1'b1, ack)
        mm.rbyte(1'b0, rb);
        mm.stop;
        `CHK("rx", 8'hc3, rb)
        rchk(`I2CS_OFF_STAT, 32'h0);
        // enable dropped after use: target must go deaf again
        wr(`I2CS_OFF_CTRL, 32'h0);
        mm.start;
        mm.wbyte(8'h54, ack);
        mm.stop;
        `CHK("ack", 1'b0, ack)
        `CHK("hung", 1'b0, hung)
        end_of_test;
    end

    // a hang ends in the closing report
    initial begin
        #2000000;
        n_fail++;
        end_of_test;
    end
endmodule : i2c_slave_controller_tb_top
